// ===== design/spi_gap_defs.vh
// register map, field positions, reset values and timing counts
`ifndef SPI_GAP_DEFS_VH
`define SPI_GAP_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_GAP        8'hf2
`define IDX_CTRL       8'hf3
`define IDX_STATUS     8'hf4
`define IDX_DATA       8'hf5
`define IDX_IRQ_EN     8'he8
`define IDX_EVT        8'he9
`define IDX_EVT_MASK   8'hea

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_SELECT_OUTPUT_ENABLE      7
`define CTRL_EN        6
`define CTRL_LSB       5
`define CTRL_CONTROLLER_MODE_SELECT      4
`define CTRL_CLOCK_POLARITY_SELECT      3
`define CTRL_CLOCK_PHASE_SELECT      2
`define CTRL_RATE_HI   1
`define CTRL_RATE_LO   0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ST_DONE        7
`define ST_WRITE_COLLISION_FLAG        6
`define ST_OVF         5
`define ST_MODE_FAULT_FLAG        4
`define ST_MODE_FAULT_DISABLE     3
`define ST_TXFULL      2

// ----------------------------------------------------------------
// interrupt enable fields
// ----------------------------------------------------------------
`define IE_SERIAL      0
`define IE_GLOBAL      1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL       8'h00
`define RST_GAP        2'h0
`define RST_DATA       8'h00
`define RST_IRQ_EN     2'h0
`define RST_EVT        8'h00
`define RST_EVT_MASK   8'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define HALF_MIN_CYC   5'h02
`define LAST_EDGE      4'hf
`define GAP_BASE_HALF  3'h1

`endif

// ===== design/spi_pin_sync.v
// two-flop synchronisers for the serial link pins
`timescale 1ns/1ns
module spi_pin_sync #(
   parameter W = 4
) (
   input  wire         sys_clk_in,
   input  wire         rst_n_in,
   input  wire         clk_en_in,
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] pin_sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta;
         reg stable;
         always @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               meta   <= 1'b1;
               stable <= 1'b1;
            end else if (clk_en_in) begin
               meta   <= pin_in[i];
               stable <= meta;
            end
         end
         assign pin_sync_out[i] = stable;
      end
   endgenerate
endmodule // spi_pin_sync

// ===== design/spi_half_tick.v
// half serial clock period tick generator for controller mode
`timescale 1ns/1ns
`include "spi_gap_defs.vh"
module spi_half_tick (
   input  wire       sys_clk_in,
   input  wire       rst_n_in,
   input  wire       clk_en_in,
   input  wire       run_in,
   input  wire [1:0] rate_in,
   output reg        tick_out
);
   reg  [4:0] cnt;
   wire [4:0] half_len;

   // half period of 2, 4, 8 or 16 system clocks
   assign half_len = `HALF_MIN_CYC << rate_in;

   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt      <= 5'h00;
         tick_out <= 1'b0;
      end else if (clk_en_in) begin
         if (!run_in) begin
            cnt      <= 5'h00;
            tick_out <= 1'b0;
         end else if (cnt == half_len - 5'h01) begin
            cnt      <= 5'h00;
            tick_out <= 1'b1;
         end else begin
            cnt      <= cnt + 5'h01;
            tick_out <= 1'b0;
         end
      end
   end
endmodule // spi_half_tick

// ===== design/spi_status_data_gap_logic.v
// serial unit: status flags, data buffers, byte gap and link engine
//
// Operation
// - gap between bytes is 1..4 half clocks, plus one with phase 1
// - transfer-done flag set when a byte completes into the read buffer
// - done flag with serial and global enables raises the interrupt
// - software clears done flag; data writes ignored while it is set
// - write collision sets a sticky flag until software clears it
// - receive overrun sets its flag and raises interrupt when enabled
// - controller, detection on, select pulled low: mode fault at once
// - fault-disable bit only matters in controller mode
// - detection on: select is fault input, else follows output enable
// - status bit 2 reads one while the transmit buffer is full
// - data write loads transmit shifter, or transmit buffer when busy, data read returns read buffer
// - each controller data write not dropped or colliding starts one full duplex byte
// - select output enable drives select low per byte, else plain pin
// - phase picks first or second sampling edge, polarity the idle level
// - bit order bit chooses msb first or lsb first
`timescale 1ns/1ns
`include "spi_gap_defs.vh"
module spi_status_data_gap_logic (
   input  wire        sys_clk_in,
   input  wire        rst_n_in,
   input  wire        clk_en_in,
   input  wire [9:0]  address_in,
   input  wire        read_in,
   input  wire        write_in,
   input  wire [31:0] writedata_in,
   input  wire [3:0]  byteenable_in,
   output reg  [31:0] readdata_out,
   output reg         waitrequest_out,
   input  wire        sclk_pin_in,
   output reg         sclk_pin_out,
   output reg         sclk_oe_n_out,
   input  wire        mosi_pin_in,
   output reg         mosi_pin_out,
   output reg         mosi_oe_n_out,
   input  wire        miso_pin_in,
   output reg         miso_pin_out,
   output reg         miso_oe_n_out,
   input  wire        ss_n_pin_in,
   output reg         ss_n_pin_out,
   output reg         ss_oe_n_out,
   output reg         irq_out
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam ST_IDLE  = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_GAP   = 3'b100;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   reg  [7:0] ctrl;
   reg  [1:0] byte_gap_select;
   reg  [1:0] irq_en;
   reg  [7:0] evt;
   reg  [7:0] evt_mask;
   reg  [7:0] rd_buf;
   reg  [7:0] tx_sh;
   reg  [7:0] tx_buf;
   reg  [7:0] rx_sh;
   reg        transfer_done_flag;
   reg        write_collision_flag;
   reg        receive_overrun_flag;
   reg        mode_fault_flag;
   reg        mode_fault_disable;
   reg        tx_buffer_full;
   reg  [2:0] st;
   reg  [3:0] edge_cnt;
   reg  [2:0] gap_cnt;
   reg        start_pend;
   reg        sclk_prev;
   reg  [7:0] rd_mux;

   // ----------------------------------------------------------------
   // pin synchronisers and half clock tick
   // ----------------------------------------------------------------
   wire [3:0] pins_s;
   wire       sclk_s;
   wire       mosi_s;
   wire       miso_s;
   wire       ss_s;
   wire       tick;

   spi_pin_sync #(
      .W            (4)
   ) u_sync (
      .sys_clk_in   (sys_clk_in),
      .rst_n_in     (rst_n_in),
      .clk_en_in    (clk_en_in),
      .pin_in       ({ss_n_pin_in, miso_pin_in, mosi_pin_in, sclk_pin_in}),
      .pin_sync_out (pins_s)
   );

   assign sclk_s = pins_s[0];
   assign mosi_s = pins_s[1];
   assign miso_s = pins_s[2];
   assign ss_s   = pins_s[3];

   // ----------------------------------------------------------------
   // control decode
   // ----------------------------------------------------------------
   wire       spi_en   = ctrl[`CTRL_EN];
   wire       ctl_mode = ctrl[`CTRL_CONTROLLER_MODE_SELECT];
   wire       clock_phase_select     = ctrl[`CTRL_CLOCK_PHASE_SELECT];
   wire       clock_polarity_select     = ctrl[`CTRL_CLOCK_POLARITY_SELECT];
   wire       lsb_1st  = ctrl[`CTRL_LSB];
   wire       select_output_enable     = ctrl[`CTRL_SELECT_OUTPUT_ENABLE];
   wire       st_idle  = st[0];
   wire       st_shift = st[1];
   wire       st_gap   = st[2];

   spi_half_tick u_tick (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .clk_en_in  (clk_en_in),
      .run_in     (ctl_mode & (st_shift | st_gap)),
      .rate_in    (ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO]),
      .tick_out   (tick)
   );

   // ----------------------------------------------------------------
   // bus access decode
   // ----------------------------------------------------------------
   wire [7:0] idx    = address_in[9:2];
   wire [7:0] wd     = writedata_in[7:0];
   wire       wr_acc = write_in & ~waitrequest_out & byteenable_in[0];
   wire       rd_acc = read_in & ~waitrequest_out;
   wire       wr_ctl = wr_acc & (idx == `IDX_CTRL);
   wire       wr_gap = wr_acc & (idx == `IDX_GAP);
   wire       wr_sts = wr_acc & (idx == `IDX_STATUS);
   wire       wr_dat = wr_acc & (idx == `IDX_DATA);
   wire       wr_ie  = wr_acc & (idx == `IDX_IRQ_EN);
   wire       wr_msk = wr_acc & (idx == `IDX_EVT_MASK);
   wire       rd_evt = rd_acc & (idx == `IDX_EVT);

   // data writes dropped while the done flag stands
   wire       wr_ok     = wr_dat & ~transfer_done_flag;
   wire       idle_load = wr_ok & st_idle;
   wire       buf_load  = wr_ok & ~st_idle & ~tx_buffer_full;
   wire       set_write_collision_flag  = wr_ok & ~st_idle & tx_buffer_full;

   // ----------------------------------------------------------------
   // link event decode
   // ----------------------------------------------------------------
   // fault detection only in controller mode, ignoring select enable
   wire mf_det = spi_en & ctl_mode & ~mode_fault_disable &
                 ~ss_s;
   wire p_edge = ~ctl_mode & st_shift & (sclk_s ^ sclk_prev);
   wire edge_evt  = ctl_mode ? (st_shift & tick) : p_edge;
   wire last_edge = edge_evt & (edge_cnt == `LAST_EDGE);
   // phase 0 samples even edges, phase 1 odd edges
   wire sample_now = edge_evt & (edge_cnt[0] == clock_phase_select);
   wire emit_now   = edge_evt & (edge_cnt[0] != clock_phase_select);
   wire rx_bit     = ctl_mode ? miso_s : mosi_s;
   wire gap_last   = st_gap & tick & (gap_cnt == 3'h1);
   wire start_c    = st_idle & start_pend & ctl_mode & spi_en & ~mf_det;
   wire start_p    = st_idle & ~ctl_mode & spi_en & ~ss_s;
   wire reload     = (ctl_mode & gap_last & tx_buffer_full) |
                     (~ctl_mode & last_edge & tx_buffer_full);
   wire begin_byte = start_c | start_p | reload | (~ctl_mode & last_edge);
   wire first_emit = begin_byte & ~clock_phase_select;
   wire [7:0] src  = reload ? tx_buf : tx_sh;
   wire set_done   = last_edge & ~transfer_done_flag;
   wire set_ovf    = last_edge & transfer_done_flag;
   wire set_mode_fault_flag   = mf_det;

   // gap in half clocks: select + 1, one more with phase 1
   wire [2:0] gap_halves = {1'b0, byte_gap_select} + `GAP_BASE_HALF +
                           {2'b00, clock_phase_select};

   // ----------------------------------------------------------------
   // bit order helpers
   // ----------------------------------------------------------------
   function pick;
      input [7:0] v;
      input       lsb;
      begin
         pick = lsb ? v[0] : v[7];
      end
   endfunction

   function [7:0] shift_out;
      input [7:0] v;
      input       lsb;
      begin
         shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
      end
   endfunction

   function [7:0] shift_in;
      input [7:0] v;
      input       b;
      input       lsb;
      begin
         shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
      end
   endfunction

   wire [7:0] rx_final = sample_now ? shift_in(rx_sh, rx_bit, lsb_1st)
                                    : rx_sh;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always @* begin
      case (idx)
         `IDX_CTRL:     rd_mux = ctrl;
         `IDX_GAP:      rd_mux = {6'h00, byte_gap_select};
         `IDX_STATUS:   rd_mux = {transfer_done_flag, write_collision_flag,
                                  receive_overrun_flag, mode_fault_flag,
                                  mode_fault_disable, tx_buffer_full,
                                  2'b00};
         `IDX_DATA:     rd_mux = rd_buf;
         `IDX_IRQ_EN:   rd_mux = {6'h00, irq_en};
         `IDX_EVT:      rd_mux = evt;
         `IDX_EVT_MASK: rd_mux = evt_mask;
         default:       rd_mux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // bus slave and registers
   // ----------------------------------------------------------------
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         waitrequest_out      <= 1'b1;
         readdata_out         <= 32'h0000_0000;
         ctrl                 <= `RST_CTRL;
         byte_gap_select      <= `RST_GAP;
         irq_en               <= `RST_IRQ_EN;
         evt                  <= `RST_EVT;
         evt_mask             <= `RST_EVT_MASK;
         transfer_done_flag   <= 1'b0;
         write_collision_flag <= 1'b0;
         receive_overrun_flag <= 1'b0;
         mode_fault_flag      <= 1'b0;
         mode_fault_disable   <= 1'b0;
         irq_out              <= 1'b0;
      end else if (clk_en_in) begin
         // one wait cycle, then acknowledge for exactly one cycle
         waitrequest_out <= ~((read_in | write_in) & waitrequest_out);
         if (read_in & waitrequest_out) begin
            readdata_out <= {24'h00_0000, rd_mux};
         end
         if (wr_ctl) begin
            ctrl <= wd;
         end
         if (wr_gap) begin
            byte_gap_select <= wd[1:0];
         end
         if (wr_ie) begin
            irq_en <= wd[1:0];
         end
         if (wr_msk) begin
            evt_mask <= wd & 8'hf0;
         end
         if (wr_sts) begin
            mode_fault_disable <= wd[`ST_MODE_FAULT_DISABLE];
         end
         // a set in the clearing cycle wins
         transfer_done_flag <= (transfer_done_flag &
                                ~(wr_sts & ~wd[`ST_DONE])) |
                               set_done;
         write_collision_flag <= (write_collision_flag &
                                  ~(wr_sts & ~wd[`ST_WRITE_COLLISION_FLAG])) |
                                 set_write_collision_flag;
         receive_overrun_flag <= (receive_overrun_flag &
                                  ~(wr_sts & ~wd[`ST_OVF])) |
                                 set_ovf;
         mode_fault_flag <= (mode_fault_flag &
                             ~(wr_sts & ~wd[`ST_MODE_FAULT_FLAG])) |
                            set_mode_fault_flag;
         evt <= (evt & ~{8{rd_evt}}) |
                {set_done, set_write_collision_flag, set_ovf, set_mode_fault_flag, 4'h0};
         irq_out <= (irq_en[`IE_SERIAL] & irq_en[`IE_GLOBAL] &
                     (transfer_done_flag | receive_overrun_flag |
                      mode_fault_flag)) |
                    (|(evt & evt_mask));
      end
   end

   // ----------------------------------------------------------------
   // byte engine
   // ----------------------------------------------------------------
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st             <= ST_IDLE;
         edge_cnt       <= 4'h0;
         gap_cnt        <= 3'h0;
         start_pend     <= 1'b0;
         tx_sh          <= `RST_DATA;
         tx_buf         <= `RST_DATA;
         rx_sh          <= `RST_DATA;
         rd_buf         <= `RST_DATA;
         tx_buffer_full <= 1'b0;
         sclk_prev      <= 1'b1;
      end else if (clk_en_in) begin
         sclk_prev <= sclk_s;
         // transmit shifter and buffer
         if (idle_load) begin
            tx_sh      <= wd;
            start_pend <= ctl_mode;
         end else if (first_emit) begin
            tx_sh <= shift_out(src, lsb_1st);
         end else if (reload) begin
            tx_sh <= tx_buf;
         end else if (emit_now) begin
            tx_sh <= shift_out(tx_sh, lsb_1st);
         end
         if (start_c | mf_det | ~ctl_mode) begin
            if (!idle_load) begin
               start_pend <= 1'b0;
            end
         end
         if (buf_load) begin
            tx_buf <= wd;
         end
         tx_buffer_full <= (tx_buffer_full & ~reload) | buf_load;
         // receive shifter and read buffer
         if (sample_now) begin
            rx_sh <= rx_final;
         end
         if (set_done) begin
            rd_buf <= rx_final;
         end
         case (st)
            ST_IDLE: begin
               edge_cnt <= 4'h0;
               if (start_c | start_p) begin
                  st <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (mf_det | ~spi_en | (~ctl_mode & ss_s)) begin
                  st <= ST_IDLE;
               end else if (edge_evt) begin
                  edge_cnt <= edge_cnt + 4'h1;
                  if (last_edge & ctl_mode) begin
                     st      <= ST_GAP;
                     gap_cnt <= gap_halves;
                  end
               end
            end
            ST_GAP: begin
               edge_cnt <= 4'h0;
               if (mf_det | ~spi_en) begin
                  st <= ST_IDLE;
               end else if (gap_last) begin
                  st <= tx_buffer_full ? ST_SHIFT : ST_IDLE;
               end else if (tick) begin
                  gap_cnt <= gap_cnt - 3'h1;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_pin_out  <= 1'b0;
         sclk_oe_n_out <= 1'b1;
         mosi_pin_out  <= 1'b1;
         mosi_oe_n_out <= 1'b1;
         miso_pin_out  <= 1'b1;
         miso_oe_n_out <= 1'b1;
         ss_n_pin_out  <= 1'b1;
         ss_oe_n_out   <= 1'b1;
      end else if (clk_en_in) begin
         // idle level from polarity, toggled on every half tick of the shift state, held at idle through the gap
         if (ctl_mode & st_shift & ~mf_det) begin
            if (tick) begin
               sclk_pin_out <= ~sclk_pin_out;
            end
         end else begin
            sclk_pin_out <= clock_polarity_select;
         end
         if (first_emit) begin
            mosi_pin_out <= pick(src, lsb_1st);
            miso_pin_out <= pick(src, lsb_1st);
         end else if (emit_now) begin
            mosi_pin_out <= pick(tx_sh, lsb_1st);
            miso_pin_out <= pick(tx_sh, lsb_1st);
         end
         sclk_oe_n_out <= ~(spi_en & ctl_mode);
         mosi_oe_n_out <= ~(spi_en & ctl_mode);
         miso_oe_n_out <= ~(spi_en & ~ctl_mode & ~ss_s);
         // select driven only with detection off and output enabled
         ss_oe_n_out  <= ~(spi_en & ctl_mode & mode_fault_disable &
                           select_output_enable);
         ss_n_pin_out <= ~st_shift;
      end
   end
endmodule // spi_status_data_gap_logic

// ===== testbench/spi_status_data_gap_logic_asserts.sv
// port relation checker for the serial status, data and gap logic
`timescale 1ns/1ns
module spi_status_data_gap_logic_asserts (
   input wire logic        sys_clk_in,
   input wire logic        rst_n_in,
   input wire logic        read_in,
   input wire logic        write_in,
   input wire logic [31:0] readdata_out,
   input wire logic        waitrequest_out,
   input wire logic        sclk_pin_out,
   input wire logic        sclk_oe_n_out,
   input wire logic        mosi_oe_n_out,
   input wire logic        miso_oe_n_out,
   input wire logic        irq_out
);
   // ----------------
   // assertions
   // ----------------
   logic any_wr;
   // enables are zero until software writes something
   always @(posedge sys_clk_in or negedge rst_n_in)
      if (!rst_n_in) any_wr <= 1'b0;
      else if (write_in) any_wr <= 1'b1;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_ACK_NEXT: assert property ((read_in || write_in)
      && waitrequest_out |=> !waitrequest_out) else $error("ack late");
   AST_ACK_ONE: assert property (!waitrequest_out
      |=> waitrequest_out) else $error("ack too long");
   AST_ACK_CAUSE: assert property ($fell(waitrequest_out)
      |-> $past(read_in || write_in)) else $error("ack without request");
   AST_RD_HOLD: assert property (!read_in |=> $stable(readdata_out))
      else $error("read data moved");
   AST_RD_UPPER: assert property (readdata_out[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_IRQ_QUIET: assert property (!any_wr |-> !irq_out)
      else $error("irq while disabled");
   AST_OE_EXCL: assert property (mosi_oe_n_out || miso_oe_n_out)
      else $error("both data pins driven");
   AST_SCLK_HALF: assert property (!sclk_oe_n_out
      && $changed(sclk_pin_out) |=> $stable(sclk_pin_out))
      else $error("clock half too short");
   cover property ($rose(irq_out));
   cover property (!sclk_oe_n_out && $changed(sclk_pin_out));
   cover property (read_in && !waitrequest_out);
endmodule // spi_status_data_gap_logic_asserts

bind spi_status_data_gap_logic spi_status_data_gap_logic_asserts
   spi_status_data_gap_logic_asserts_i (.*);

// ===== testbench/spi_peer_model.sv
// behavioural serial peripheral on the far side of the link
`timescale 1ns/1ns
module spi_peer_model (
   input  wire logic       sclk_in,
   input  wire logic       ss_n_in,
   input  wire logic       mosi_in,
   input  wire logic       clock_polarity_select_in,
   input  wire logic       clock_phase_select_in,
   input  wire logic       lsb_in,
   input  wire logic [7:0] tx_in,
   output logic            miso_out,
   output logic [7:0]      rx_out
);
   int n;
   function automatic logic pick(input int i);
      return lsb_in ? tx_in[i & 7] : tx_in[7 - (i & 7)];
   endfunction
   initial begin
      miso_out = 1'b1;
      rx_out = 8'h00;
      n = 0;
   end
   always @(negedge ss_n_in) begin
      n = 0;
      if (!clock_phase_select_in) miso_out = pick(0);
   end
   // released line shows no stale bit
   always @(posedge ss_n_in) miso_out = ~miso_out;
   always @(sclk_in) if (!ss_n_in) begin
      if ((sclk_in != clock_polarity_select_in) != clock_phase_select_in)
         rx_out = lsb_in ? {mosi_in, rx_out[7:1]}
                         : {rx_out[6:0], mosi_in};
      else begin
         n++;
         miso_out = pick(clock_phase_select_in ? n - 1 : n);
      end
   end
endmodule // spi_peer_model

// ===== testbench/tb_spi_status_data_gap_logic.sv
// self-checking bench for the serial status, data and gap logic
`timescale 1ns/1ns
`include "spi_gap_defs.vh"
module tb_spi_status_data_gap_logic;
   logic        sys_clk_in, rst_n_in, read_in, write_in;
   logic        ss_drv, clock_polarity_select, clock_phase_select, lsb;
   logic [9:0]  address_in;
   logic [31:0] writedata_in;
   logic [7:0]  tx, rx, v;
   logic [7:0]  regs [8] = '{`IDX_STATUS, `IDX_DATA, `IDX_GAP, `IDX_CTRL,
                              `IDX_IRQ_EN, `IDX_EVT, `IDX_EVT_MASK, 8'h10};
   wire  [31:0] readdata_out;
   wire         waitrequest_out, sclk_pin_out, sclk_oe_n_out, mosi_pin_out,
                mosi_oe_n_out, miso_pin_out, miso_oe_n_out, ss_n_pin_out,
                ss_oe_n_out, irq_out, peer_miso;
   wire         clk_en_in = 1'b1;
   wire  [3:0]  byteenable_in = 4'h1;
   wire         sclk_pin_in = sclk_oe_n_out ? clock_polarity_select : sclk_pin_out;
   wire         mosi_pin_in = mosi_oe_n_out ? 1'b1 : mosi_pin_out;
   wire         miso_pin_in = miso_oe_n_out ? peer_miso : miso_pin_out;
   wire         ss_n_pin_in = ss_oe_n_out ? ss_drv : ss_n_pin_out;
   int          error_cnt, n_compared, hi, last_hi, falls, r, q, e;
   spi_status_data_gap_logic spi_status_data_gap_logic_i (.*);
   spi_peer_model spi_peer_model_i (.sclk_in(sclk_pin_in),
      .ss_n_in(ss_n_pin_in), .mosi_in(mosi_pin_in), .clock_polarity_select_in(clock_polarity_select),
      .clock_phase_select_in(clock_phase_select), .lsb_in(lsb), .tx_in(tx), .miso_out(peer_miso),
      .rx_out(rx));
   // ----------------
   // tasks
   // ----------------
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   // select high time before each fall
   always @(posedge sys_clk_in) begin
      hi <= ss_n_pin_in ? hi + 1 : 0;
      if (!ss_n_pin_in && hi != 0) begin
         last_hi <= hi;
         falls <= falls + 1;
      end
   end
   task automatic close_out(input bit hang);
      if (hang) error_cnt++;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, d);
      int t;
      @(posedge sys_clk_in);
      address_in <= {idx, 2'b00};
      writedata_in <= {24'h0, d};
      write_in <= wr;
      read_in <= !wr;
      t = 0;
      do begin
         @(posedge sys_clk_in);
         t++;
      end while (waitrequest_out !== 1'b0 && t < 40);
      if (t >= 40) close_out(1);
      v = readdata_out[7:0];
      write_in <= 1'b0;
      read_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, e, input string s);
      bus(1'b0, idx, 8'h00);
      chk(s, v, e);
   endtask
   task automatic wait_st(input int k);
      for (int t = 0; t < 400; t++) begin
         bus(1'b0, `IDX_STATUS, 8'h00);
         if (v[k] === 1'b1) return;
      end
      close_out(1);
   endtask
   // ----------------
   // sequence
   // ----------------
   initial begin
      {read_in, write_in, address_in, writedata_in} = '0;
      {clock_polarity_select, clock_phase_select, lsb, tx, ss_drv} = 12'h001;
      {error_cnt, n_compared, hi, falls, last_hi} = '0;
      void'($urandom(47));
      rst_n_in = 1'b0;
      repeat (20) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00, "reset");
      bus(1'b1, `IDX_GAP, 8'hff);
      rd(`IDX_GAP, 8'h03, "gap");
      bus(1'b1, `IDX_STATUS, 8'hff);
      rd(`IDX_STATUS, 8'h08, "status");
      bus(1'b1, 8'h10, 8'hff);
      rd(8'h10, 8'h00, "unmapped");
      for (int k = 0; k < 6; k++) begin
         r = $urandom;
         q = $urandom;
         {clock_polarity_select, clock_phase_select, lsb} <= r[2:0];
         tx <= q[23:16];
         // rate 1: link clock of 160 ns
         bus(1'b1, `IDX_CTRL, {2'b11, r[0], 1'b1, r[2:1], 2'b01});
         bus(1'b1, `IDX_STATUS, 8'h08);
         bus(1'b1, `IDX_IRQ_EN, {6'h0, r[8:7]});
         bus(1'b1, `IDX_EVT_MASK, {r[9], 7'h0});
         bus(1'b1, `IDX_GAP, {6'h0, r[6:5]});
         falls = 0;
         bus(1'b1, `IDX_DATA, q[7:0]);
         bus(1'b1, `IDX_DATA, q[15:8]);
         bus(1'b1, `IDX_DATA, 8'h5a);
         rd(`IDX_STATUS, 8'h4c, "busy");
         chk("oe", {sclk_oe_n_out, ss_oe_n_out}, 8'h00);
         wait_st(5);
         rd(`IDX_STATUS, 8'he8, "flags");
         rd(`IDX_DATA, tx, "rxbuf");
         chk("peer", rx, q[15:8]);
         chk("idle", sclk_pin_in, clock_polarity_select);
         chk("irq", irq_out, r[8:7] == 2'h3 || r[9]);
         e = (r[6:5] + 1 + r[1]) * 4;
         chk("gapcyc", last_hi >= e - 1 && last_hi <= e + 2, 1);
         rd(`IDX_EVT, 8'he0, "event");
         bus(1'b1, `IDX_DATA, 8'h33);
         chk("irqen", irq_out, r[8:7] == 2'h3);
         bus(1'b1, `IDX_STATUS, 8'h08);
         repeat (20) @(posedge sys_clk_in);
         rd(`IDX_STATUS, 8'h08, "clear");
         chk("bytes", 8'(falls), 8'h02);
         chk("irq0", irq_out, 1'b0);
      end
      bus(1'b1, `IDX_IRQ_EN, 8'h03);
      bus(1'b1, `IDX_CTRL, 8'h40);
      bus(1'b1, `IDX_STATUS, 8'h00);
      ss_drv <= 1'b0;
      repeat (10) @(posedge sys_clk_in);
      rd(`IDX_STATUS, 8'h00, "periph");
      bus(1'b1, `IDX_CTRL, 8'hd0);
      repeat (3) @(posedge sys_clk_in);
      rd(`IDX_STATUS, 8'h10, "fault");
      chk("irqf", irq_out, 1'b1);
      chk("ssin", ss_oe_n_out, 1'b1);
      close_out(0);
   end
endmodule // tb_spi_status_data_gap_logic
